// *** logic/led_fault_pkg.sv ***
package led_fault_pkg;

  // register byte offsets
  localparam logic [7:0] status_offset   = 8'h00;
  localparam logic [7:0] mask_offset     = 8'h04;
  localparam logic [7:0] control_offset  = 8'h08;
  localparam logic [7:0] live_offset     = 8'h0c;
  localparam logic [7:0] config_offset   = 8'h10;

  // status / mask / live bit positions
  localparam int short_led_bit   = 0;
  localparam int string_short_bit = 1;
  localparam int open_led_bit    = 2;
  localparam int override_bit    = 3;
  localparam int event_count     = 4;

  // control bit positions
  localparam int enable_bit      = 0;

  // reset values
  localparam logic [3:0]  status_reset  = 4'h0;
  localparam logic [3:0]  mask_reset    = 4'h0;
  localparam logic        enable_reset  = 1'b0;

  // timing: oscillator periods; osc_div_default is hclk cycles per period
  localparam int disable_periods       = 32768;
  localparam int startup_blank_periods = 1024;
  localparam int open_timeout_periods  = 4096;
  localparam int osc_div_default       = 50;

  typedef struct packed {
    logic short_led;
    logic string_short;
    logic open_led;
    logic fatal_pulled_low;
  } sense_s;

  typedef enum logic [1:0] {
    resp_okay  = 2'b00
  } resp_t;

endpackage

// *** logic/sense_sync.sv ***
`timescale 1ns/1ps
module sense_sync #(
  parameter int width = 4
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [width-1:0] async_in,
  output logic      [width-1:0] sync_out
);
  logic [width-1:0] stage1_ff;
  logic [width-1:0] stage2_ff;
  logic [width-1:0] stage3_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
      stage3_ff <= '0;
    end else begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
    end
  end

  // a bit changes only once the last two stages agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < width; i++) begin
        if (stage2_ff[i] == stage3_ff[i]) begin
          sync_out[i] <= stage3_ff[i];
        end
      end
    end
  end
endmodule

// *** logic/osc_tick.sv ***
`timescale 1ns/1ps
module osc_tick #(
  parameter int div = 50
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      tick
);
  logic [15:0] count_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_ff <= '0;
      tick     <= 1'b0;
    end else if (count_ff == 16'(div - 1)) begin
      count_ff <= '0;
      tick     <= 1'b1;
    end else begin
      count_ff <= count_ff + 16'h0001;
      tick     <= 1'b0;
    end
  end
endmodule

// *** logic/led_string_fault_supervisor.sv ***
`timescale 1ns/1ps
// Behaviour
// - open-LED detection ignores start-up blanking
// - shorted LED from either offset comparator
// - shorted LED releases warning flag, keeps switching
// - shorted LED indication follows condition, unlatched
// - string short when ratio below threshold
// - string short latched until long disable
// - string short forces gate drive low
// - string short releases fatal flag
// - fatal flag pulled low resumes drive, keeps latch
// - disable time is fixed oscillator period count
// - open LED: gate off, warning, timed retry
// - blanking period after start before short detection
// - flags pull down when fine, release on fault
module led_string_fault_supervisor #(
  parameter int osc_div          = led_fault_pkg::osc_div_default,
  parameter int disable_count    = led_fault_pkg::disable_periods,
  parameter int blank_count      = led_fault_pkg::startup_blank_periods,
  parameter int open_retry_count = led_fault_pkg::open_timeout_periods
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ratio_above_ref_cmp,
  input  wire logic        ref_above_ratio_cmp,
  input  wire logic        ratio_below_short_cmp,
  input  wire logic        ratio_above_open_cmp,
  input  wire logic        fatal_fault_flag_in,
  input  wire logic        pwm_gate_request,
  output logic             fatal_fault_flag_out,
  output logic             fatal_fault_flag_oe,
  output logic             warning_fault_flag_out,
  output logic             warning_fault_flag_oe,
  output logic             switch_gate_drive_out,
  output logic             irq
);

  typedef enum {idle_st, blank_st, run_st} run_state_e;
  typedef enum {open_clear_st, open_hold_st} open_state_e;

  function automatic logic [31:0] reg_word(input logic [3:0] bits);
    reg_word = {28'h0000000, bits};
  endfunction

  logic        tick;
  logic [4:0]  raw_in;
  logic [4:0]  sync_in;
  led_fault_pkg::sense_s sense;

  osc_tick #(.div(osc_div)) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick)
  );

  assign raw_in = {fatal_fault_flag_in, ratio_above_open_cmp, ratio_below_short_cmp,
                   ref_above_ratio_cmp, ratio_above_ref_cmp};

  sense_sync #(.width(5)) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (raw_in),
    .sync_out (sync_in)
  );

  always_comb begin
    sense.short_led        = sync_in[0] | sync_in[1];
    sense.string_short     = sync_in[2];
    sense.open_led         = sync_in[3];
    sense.fatal_pulled_low = ~sync_in[4];
  end

  // bus slave
  logic        wr_pend_ff;
  logic [7:0]  addr_ff;
  logic        rd_pend_ff;
  logic [3:0]  status_ff;
  logic [3:0]  mask_ff;
  logic        enable_ff;
  logic        bus_take;
  logic        wr_take;

  assign bus_take = hsel & hready & htrans[1];
  assign wr_take  = wr_pend_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff    <= 8'h00;
    end else begin
      wr_pend_ff <= bus_take & hwrite;
      rd_pend_ff <= bus_take & ~hwrite;
      if (bus_take) begin
        addr_ff <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // run sequencing
  run_state_e  run_ff;
  logic [15:0] run_cnt_ff;
  logic [15:0] low_cnt_ff;
  logic        long_disable;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_ff <= led_fault_pkg::enable_reset;
      mask_ff   <= led_fault_pkg::mask_reset;
    end else if (wr_take) begin
      if (addr_ff == led_fault_pkg::control_offset) begin
        enable_ff <= hwdata[led_fault_pkg::enable_bit];
      end
      if (addr_ff == led_fault_pkg::mask_offset) begin
        mask_ff <= hwdata[3:0];
      end
    end
  end

  // enable low time counted in oscillator periods
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt_ff   <= '0;
      long_disable <= 1'b0;
    end else if (enable_ff) begin
      low_cnt_ff   <= '0;
      long_disable <= 1'b0;
    end else if (tick) begin
      if (low_cnt_ff == 16'(disable_count - 1)) begin
        long_disable <= 1'b1;
      end else begin
        low_cnt_ff <= low_cnt_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_ff     <= idle_st;
      run_cnt_ff <= '0;
    end else begin
      unique case (run_ff)
        idle_st: begin
          run_cnt_ff <= '0;
          if (enable_ff) begin
            run_ff <= blank_st;
          end
        end
        blank_st: begin
          if (!enable_ff) begin
            run_ff <= idle_st;
          end else if (tick) begin
            if (run_cnt_ff == 16'(blank_count - 1)) begin
              run_ff <= run_st;
            end else begin
              run_cnt_ff <= run_cnt_ff + 16'h0001;
            end
          end
        end
        run_st: begin
          if (!enable_ff) begin
            run_ff <= idle_st;
          end
        end
      endcase
    end
  end

  logic detect_on;
  assign detect_on = (run_ff == run_st);

  // string short latch
  logic string_latch_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      string_latch_ff <= 1'b0;
    end else if (detect_on && sense.string_short) begin
      string_latch_ff <= 1'b1;
    end else if (long_disable) begin
      string_latch_ff <= 1'b0;
    end
  end

  // open LED retry, active whenever enabled
  open_state_e open_ff;
  logic [15:0] open_cnt_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      open_ff     <= open_clear_st;
      open_cnt_ff <= '0;
    end else begin
      unique case (open_ff)
        open_clear_st: begin
          open_cnt_ff <= '0;
          if (enable_ff && sense.open_led) begin
            open_ff <= open_hold_st;
          end
        end
        open_hold_st: begin
          if (!enable_ff) begin
            open_ff <= open_clear_st;
          end else if (tick) begin
            if (open_cnt_ff == 16'(open_retry_count - 1)) begin
              open_ff <= open_clear_st;
            end else begin
              open_cnt_ff <= open_cnt_ff + 16'h0001;
            end
          end
        end
      endcase
    end
  end

  logic short_now;
  logic open_now;
  logic override_now;
  assign short_now    = detect_on & sense.short_led;
  assign open_now     = (open_ff == open_hold_st);
  assign override_now = string_latch_ff & sense.fatal_pulled_low;

  // pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      switch_gate_drive_out <= 1'b0;
      fatal_fault_flag_oe   <= 1'b1;
      warning_fault_flag_oe <= 1'b1;
    end else begin
      switch_gate_drive_out <= enable_ff && pwm_gate_request && !open_now
                               && (!string_latch_ff || override_now);
      fatal_fault_flag_oe   <= !string_latch_ff;
      warning_fault_flag_oe <= !(short_now || open_now);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fatal_fault_flag_out   <= 1'b0;
      warning_fault_flag_out <= 1'b0;
    end else begin
      fatal_fault_flag_out   <= 1'b0;
      warning_fault_flag_out <= 1'b0;
    end
  end

  // sticky status, set wins over clear
  logic [3:0] events;
  logic [3:0] clear_bits;
  assign events = {override_now, open_now, string_latch_ff, short_now};
  assign clear_bits = (wr_take && addr_ff == led_fault_pkg::status_offset) ? hwdata[3:0] : 4'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_ff <= led_fault_pkg::status_reset;
    end else begin
      status_ff <= (status_ff & ~clear_bits) | events;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status_ff & ~clear_bits) | events) & mask_ff);
    end
  end

  // read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (bus_take && !hwrite) begin
      unique case (haddr[7:0])
        led_fault_pkg::status_offset:  hrdata <= reg_word(status_ff);
        led_fault_pkg::mask_offset:    hrdata <= reg_word(mask_ff);
        led_fault_pkg::control_offset: hrdata <= reg_word({3'h0, enable_ff});
        led_fault_pkg::live_offset:    hrdata <= reg_word(events);
        led_fault_pkg::config_offset:  hrdata <= reg_word({2'h0, detect_on, run_ff == blank_st});
        default:                       hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// *** bench/fault_checker.sv ***
`timescale 1ns/1ps
module fault_checker #(
  parameter int osc_div          = 50,
  parameter int open_retry_count = 4096
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        ratio_above_ref_cmp,
  input wire logic        ref_above_ratio_cmp,
  input wire logic        ratio_above_open_cmp,
  input wire logic        fatal_fault_flag_in,
  input wire logic        pwm_gate_request,
  input wire logic        fatal_fault_flag_out,
  input wire logic        fatal_fault_flag_oe,
  input wire logic        warning_fault_flag_out,
  input wire logic        warning_fault_flag_oe,
  input wire logic        switch_gate_drive_out
);
  logic [15:0] quiet_ff;
  // cycles since any shorted-LED or open comparator was last high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) quiet_ff <= 16'h0;
    else if (ratio_above_ref_cmp | ref_above_ratio_cmp | ratio_above_open_cmp) quiet_ff <= 16'h0;
    else if (quiet_ff != 16'hffff) quiet_ff <= quiet_ff + 16'h1;
  end
  logic calm;
  assign calm = quiet_ff > 16'(osc_div * open_retry_count + 16);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_fatal_pin_low: assert property (!fatal_fault_flag_out) else $error("fatal pin value high");
  a_warn_pin_low: assert property (!warning_fault_flag_out) else $error("warning pin value high");
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus wait or error seen");
  a_quiet_warn_low: assert property (calm |-> warning_fault_flag_oe) else $error("warning kept released");
  a_latch_gate_off: assert property ((!fatal_fault_flag_oe && fatal_fault_flag_in) [*6] |-> !switch_gate_drive_out)
    else $error("gate driven during latched short");
  a_override_drive: assert property ((!fatal_fault_flag_oe && !fatal_fault_flag_in && pwm_gate_request && calm) [*8]
    |-> switch_gate_drive_out) else $error("override did not resume gate");
  a_gate_needs_req: assert property (switch_gate_drive_out |-> $past(pwm_gate_request) || $past(pwm_gate_request, 2))
    else $error("gate high without request");
  a_rdata_holds: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata))
    else $error("read data changed without read");
endmodule

bind led_string_fault_supervisor fault_checker #(.osc_div(osc_div), .open_retry_count(open_retry_count))
  fault_checker_inst (.*);

// *** bench/led_sense_model.sv ***
`timescale 1ns/1ps
module led_sense_model (
  input  wire logic [3:0] cmd,
  input  wire logic       hold_low,
  input  wire logic       fatal_fault_flag_out,
  input  wire logic       fatal_fault_flag_oe,
  input  wire logic       warning_fault_flag_out,
  input  wire logic       warning_fault_flag_oe,
  output logic            ratio_above_ref_cmp,
  output logic            ref_above_ratio_cmp,
  output logic            ratio_below_short_cmp,
  output logic            ratio_above_open_cmp,
  output logic            fatal_fault_flag_in,
  output logic            warn_wire
);
  // cmd: ref short, nonref short, string short, open
  assign {ratio_above_ref_cmp, ref_above_ratio_cmp, ratio_below_short_cmp, ratio_above_open_cmp} = cmd;
  // pull-ups win unless a party sinks the wire
  assign fatal_fault_flag_in = !(fatal_fault_flag_oe && !fatal_fault_flag_out) && !hold_low;
  assign warn_wire = !(warning_fault_flag_oe && !warning_fault_flag_out);
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hreadyout, hresp, irq, hold_low, warn_wire;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  cmd;
  logic        ratio_above_ref_cmp, ref_above_ratio_cmp, ratio_below_short_cmp, ratio_above_open_cmp;
  logic        fatal_fault_flag_in, pwm_gate_request, switch_gate_drive_out;
  logic        fatal_fault_flag_out, fatal_fault_flag_oe, warning_fault_flag_out, warning_fault_flag_oe;
  wire         hready = hreadyout;
  int          fail_count = 0;
  int          check_count = 0;
  always #25 hclk = ~hclk;
  led_string_fault_supervisor #(.osc_div(2), .disable_count(8), .blank_count(4), .open_retry_count(4))
    led_string_fault_supervisor_inst (.*);
  led_sense_model led_sense_model_inst (.*);
  task close_out;
    $display("comparisons %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 20);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 40);
    q = hrdata;
    if (n >= 20) begin
      fail_count++;
      close_out();
    end
  endtask
  task rd(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask
  task wt(input int n);
    repeat (n) @(posedge hclk);
    #5;
  endtask
  task set(input logic [3:0] c);
    @(posedge hclk);
    cmd <= c;
  endtask
  // expected gate, fatal wire, warning wire
  task pins(input logic [2:0] e);
    chk("pins", {29'h0, e}, {29'h0, switch_gate_drive_out, fatal_fault_flag_in, warn_wire});
  endtask
  initial begin
    hresetn = 1'b0; hsel = 1'b1; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    cmd = 4'h0; hold_low = 1'b0; pwm_gate_request = 1'b1;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    wt(1);
    pins(3'b000);
    rd("status", led_fault_pkg::status_offset, 32'h0);
    rd("mask", led_fault_pkg::mask_offset, 32'h0);
    rd("control", led_fault_pkg::control_offset, 32'h0);
    rd("unmapped", 8'h20, 32'h0);
    bus(1'b1, led_fault_pkg::mask_offset, 32'h4);
    bus(1'b1, led_fault_pkg::control_offset, 32'h1);
    set(4'h1);
    wt(8);
    pins(3'b001);
    chk("irq", 32'h1, 32'(irq));
    set(4'h0);
    wt(40);
    pins(3'b100);
    rd("status", led_fault_pkg::status_offset, 32'h4);
    rd("config", led_fault_pkg::config_offset, 32'h2);
    rd("live", led_fault_pkg::live_offset, 32'h0);
    bus(1'b1, led_fault_pkg::status_offset, 32'h4);
    wt(3);
    chk("irq", 32'h0, 32'(irq));
    bus(1'b1, led_fault_pkg::mask_offset, 32'h0);
    for (int i = 0; i < 2; i++) begin
      set(i == 0 ? 4'h8 : 4'h4);
      wt(10);
      pins(3'b101);
      set(4'h0);
      wt(12);
      pins(3'b100);
    end
    chk("irq", 32'h0, 32'(irq));
    rd("status", led_fault_pkg::status_offset, 32'h1);
    bus(1'b1, led_fault_pkg::mask_offset, 32'h1);
    wt(3);
    chk("irq", 32'h1, 32'(irq));
    bus(1'b1, led_fault_pkg::status_offset, 32'h1);
    wt(3);
    chk("irq", 32'h0, 32'(irq));
    set(4'h2);
    wt(10);
    set(4'h0);
    wt(10);
    pins(3'b010);
    @(posedge hclk);
    hold_low <= 1'b1;
    wt(12);
    chk("gate", 32'h1, 32'(switch_gate_drive_out));
    rd("status", led_fault_pkg::status_offset, 32'ha);
    @(posedge hclk);
    hold_low <= 1'b0;
    wt(10);
    pins(3'b010);
    bus(1'b1, led_fault_pkg::control_offset, 32'h0);
    wt(4);
    bus(1'b1, led_fault_pkg::control_offset, 32'h1);
    wt(10);
    pins(3'b010);
    bus(1'b1, led_fault_pkg::control_offset, 32'h0);
    wt(40);
    chk("fatal", 32'h0, 32'(fatal_fault_flag_in));
    close_out();
  end
endmodule
